// ==== verilog/sbru_rotate_unit.sv ====
// Purpose: one-bit rotate datapath of the 16-bit core
// Assumes: decoder presents the instruction and fetched operand together
// Notes: result is registered, one cycle after the instruction is taken
//
// What this block does
// - file left rotate: top bit into bit0.
// - file right rotate: bit0 into top bit; via carry, carry into top bit and bit0 into carry.
// - destination bit 0 working reg, 1 file.
// - working operand given stores there, else file.
// - default working register is index zero.
// - file forms: size 0 word, 1 byte.
// - working left rotate: size 0 byte, 1 word.
// - 3-bit source and destination mode fields.
// - 4-bit source and destination register indices.
// - file address taken from 13-bit field.
// - one word, result one cycle later.
`timescale 1ns/1ps
module sbru_rotate_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [sbru_pkg::INSTR_W-1:0] i_instr,
  input wire logic [sbru_pkg::DATA_W-1:0] i_operand,
  input wire logic [sbru_pkg::DATA_W-1:0] i_dst_old,
  input wire logic i_carry,
  output sbru_pkg::sbru_res_type o_res,
  output logic o_done,
  output logic o_illegal
);

  sbru_pkg::sbru_op_type op;
  logic legal;
  logic file_form;
  logic byte_op;
  logic top_in;
  logic [sbru_pkg::DATA_W-1:0] rot_val;
  sbru_pkg::sbru_res_type res_nxt;
  sbru_pkg::sbru_res_type res_r;
  logic done_r;
  logic illegal_r;
  // assertion helpers: inputs of the last valid instruction, refused ones included
  logic [sbru_pkg::DATA_W-1:0] op_in_r;
  logic [sbru_pkg::DATA_W-1:0] dst_in_r;
  logic carry_in_r;
  logic [sbru_pkg::INSTR_W-1:0] instr_in_r;

  // decode of form, direction and size
  always_comb begin
    file_form = i_instr[sbru_pkg::FILE_FORM_BIT];
    legal = (i_instr[sbru_pkg::OPC_HI:sbru_pkg::OPC_LO] == sbru_pkg::OPC_ROTATE)
      && !i_instr[sbru_pkg::FORM_ZERO_BIT] && i_instr[sbru_pkg::FORM_ONE_BIT];
    op = sbru_pkg::OP_NONE;
    if (legal) begin
      case ({i_instr[sbru_pkg::RIGHT_BIT], i_instr[sbru_pkg::CARRY_BIT]})
        2'b00: op = sbru_pkg::OP_ROTL_PLAIN;
        2'b10: op = sbru_pkg::OP_ROTR_PLAIN;
        2'b11: op = sbru_pkg::OP_ROTR_VIA_CARRY;
        default: op = sbru_pkg::OP_NONE; // left through carry is not handled here
      endcase
    end
    if (file_form) begin
      byte_op = i_instr[sbru_pkg::SIZE_BIT];
    end else if (op == sbru_pkg::OP_ROTL_PLAIN) begin
      byte_op = !i_instr[sbru_pkg::SIZE_BIT];
    end else begin
      byte_op = i_instr[sbru_pkg::SIZE_BIT];
    end
  end

  // rotate by one at byte or word width
  always_comb begin
    top_in = i_operand[0];
    if (op == sbru_pkg::OP_ROTR_VIA_CARRY) begin
      top_in = i_carry;
    end
    rot_val = i_dst_old;
    case (op)
      sbru_pkg::OP_ROTL_PLAIN: begin
        if (byte_op) begin
          rot_val[sbru_pkg::BYTE_TOP:0] = {i_operand[sbru_pkg::BYTE_TOP-1:0],
            i_operand[sbru_pkg::BYTE_TOP]};
        end else begin
          rot_val = {i_operand[sbru_pkg::WORD_TOP-1:0],
            i_operand[sbru_pkg::WORD_TOP]};
        end
      end
      sbru_pkg::OP_ROTR_PLAIN, sbru_pkg::OP_ROTR_VIA_CARRY: begin
        if (byte_op) begin
          rot_val[sbru_pkg::BYTE_TOP:0] = {top_in,
            i_operand[sbru_pkg::BYTE_TOP:1]};
        end else begin
          rot_val = {top_in, i_operand[sbru_pkg::WORD_TOP:1]};
        end
      end
      default: rot_val = i_dst_old;
    endcase
  end

  // assemble write-back bundle and flags
  always_comb begin
    res_nxt = res_r;
    res_nxt.value = rot_val;
    res_nxt.byte_op = byte_op;
    res_nxt.file_addr = i_instr[sbru_pkg::FADDR_HI:0];
    res_nxt.dst_mode = i_instr[sbru_pkg::DMODE_HI:sbru_pkg::DMODE_LO];
    res_nxt.src_mode = i_instr[sbru_pkg::SMODE_HI:sbru_pkg::SMODE_LO];
    res_nxt.src_idx = i_instr[sbru_pkg::SIDX_HI:sbru_pkg::SIDX_LO];
    if (file_form) begin
      res_nxt.dest_is_file = i_instr[sbru_pkg::DEST_BIT];
      res_nxt.dst_idx = sbru_pkg::WORKING_REG_ZERO;
      res_nxt.dst_mode = '0;
      res_nxt.src_mode = '0;
      res_nxt.src_idx = sbru_pkg::WORKING_REG_ZERO;
    end else begin
      res_nxt.dest_is_file = 1'b0;
      res_nxt.dst_idx = i_instr[sbru_pkg::DIDX_HI:sbru_pkg::DIDX_LO];
      res_nxt.file_addr = '0;
    end
    res_nxt.carry_we = (op == sbru_pkg::OP_ROTR_VIA_CARRY);
    res_nxt.carry = (op == sbru_pkg::OP_ROTR_VIA_CARRY) ? i_operand[0] : i_carry;
    if (byte_op) begin
      res_nxt.neg = rot_val[sbru_pkg::BYTE_TOP];
      res_nxt.zero = (rot_val[sbru_pkg::BYTE_TOP:0] == sbru_pkg::ZERO_BYTE);
    end else begin
      res_nxt.neg = rot_val[sbru_pkg::WORD_TOP];
      res_nxt.zero = (rot_val == sbru_pkg::ZERO_WORD);
    end
  end

  // result register, written once per taken instruction
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      res_r <= '0;
    end else if (i_ce && i_valid && op != sbru_pkg::OP_NONE) begin
      res_r <= res_nxt;
    end
  end

  // completion and refusal strobes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
    end else if (i_ce) begin
      done_r <= i_valid && op != sbru_pkg::OP_NONE;
      illegal_r <= i_valid && op == sbru_pkg::OP_NONE;
    end
  end

  // captured inputs for checking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      op_in_r <= '0;
      dst_in_r <= '0;
      carry_in_r <= 1'b0;
      instr_in_r <= '0;
    end else if (i_ce && i_valid) begin
      op_in_r <= i_operand;
      dst_in_r <= i_dst_old;
      carry_in_r <= i_carry;
      instr_in_r <= i_instr;
    end
  end

  assign o_res = res_r;
  assign o_done = done_r;
  assign o_illegal = illegal_r;

  // file word left rotate
  AST_ROTL_FILE_WORD: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && instr_in_r[sbru_pkg::FILE_FORM_BIT] && !instr_in_r[sbru_pkg::RIGHT_BIT]
     && !instr_in_r[sbru_pkg::SIZE_BIT]) |->
    (o_res.value == {op_in_r[sbru_pkg::WORD_TOP-1:0], op_in_r[sbru_pkg::WORD_TOP]}
     && !o_res.carry_we))
    else $error("file word left rotate wrong");
  // file byte right rotate keeps upper byte
  AST_ROTR_FILE_BYTE: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && instr_in_r[sbru_pkg::FILE_FORM_BIT] && instr_in_r[sbru_pkg::RIGHT_BIT]
     && !instr_in_r[sbru_pkg::CARRY_BIT] && instr_in_r[sbru_pkg::SIZE_BIT]) |->
    (o_res.value == {dst_in_r[15:8], op_in_r[0], op_in_r[7:1]}))
    else $error("file byte right rotate wrong");
  // destination select of file forms
  AST_FILE_DEST: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && instr_in_r[sbru_pkg::FILE_FORM_BIT]) |->
    (o_res.dest_is_file == instr_in_r[sbru_pkg::DEST_BIT]
     && o_res.dst_idx == sbru_pkg::WORKING_REG_ZERO))
    else $error("file form destination wrong");
  // file forms: size bit set means byte
  AST_FILE_SIZE: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && instr_in_r[sbru_pkg::FILE_FORM_BIT]) |->
    (o_res.byte_op == instr_in_r[sbru_pkg::SIZE_BIT]))
    else $error("file form size select wrong");
  // file address passed through unchanged
  AST_FILE_ADDR: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && instr_in_r[sbru_pkg::FILE_FORM_BIT]) |->
    (o_res.file_addr == instr_in_r[sbru_pkg::FADDR_HI:0]))
    else $error("file address wrong");
  // working left rotate byte when size bit low
  AST_ROTL_W_SIZE: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && !instr_in_r[sbru_pkg::FILE_FORM_BIT] && !instr_in_r[sbru_pkg::RIGHT_BIT]
     && !instr_in_r[sbru_pkg::SIZE_BIT]) |->
    (o_res.byte_op && o_res.value[7:0] == {op_in_r[6:0], op_in_r[7]}))
    else $error("working left rotate size wrong");
  // carry shifts through on word right rotate via carry
  AST_VIA_CARRY: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_valid && op == sbru_pkg::OP_ROTR_VIA_CARRY && !byte_op) ##1 o_done |->
    (o_res.carry == op_in_r[0] && o_res.value[15] == carry_in_r && o_res.carry_we))
    else $error("rotate via carry wrong");
  // register fields of working forms
  AST_W_FIELDS: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && !instr_in_r[sbru_pkg::FILE_FORM_BIT]) |->
    (o_res.dst_idx == instr_in_r[sbru_pkg::DIDX_HI:sbru_pkg::DIDX_LO]
     && o_res.src_idx == instr_in_r[sbru_pkg::SIDX_HI:sbru_pkg::SIDX_LO]
     && o_res.dst_mode == instr_in_r[sbru_pkg::DMODE_HI:sbru_pkg::DMODE_LO]
     && o_res.src_mode == instr_in_r[sbru_pkg::SMODE_HI:sbru_pkg::SMODE_LO]))
    else $error("working register fields wrong");
  // one cycle from taken to done
  AST_ONE_CYCLE: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_ce && i_valid && op != sbru_pkg::OP_NONE) |=> o_done)
    else $error("rotate did not complete in one cycle");
  // flags follow result at its width
  AST_FLAGS: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> (o_res.byte_op ? (o_res.neg == o_res.value[7]
      && o_res.zero == (o_res.value[7:0] == 8'h00)) : (o_res.neg == o_res.value[15]
      && o_res.zero == (o_res.value == 16'h0000))))
    else $error("negative or zero flag wrong");
  // byte ops leave upper byte as it was
  AST_BYTE_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_done && o_res.byte_op) |-> (o_res.value[15:8] == dst_in_r[15:8]))
    else $error("byte rotate touched upper byte");

endmodule // sbru_rotate_unit

// ==== verilog/sbru_pkg.sv ====
// Purpose: shared constants and types for the single bit rotate unit
// Assumes: 24-bit instruction word, 16-bit data path
// Notes: field positions follow the rotate instruction encodings
package sbru_pkg;
  // instruction word layout
  localparam int INSTR_W = 24;
  localparam int DATA_W = 16;
  localparam int FADDR_W = 13;
  localparam int WIDX_W = 4;
  localparam int MODE_W = 3;
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 20;
  localparam logic [3:0] OPC_ROTATE = 4'hD;
  localparam int FORM_ZERO_BIT = 19;
  localparam int FILE_FORM_BIT = 18;
  localparam int FORM_ONE_BIT = 17;
  localparam int RIGHT_BIT = 16;
  localparam int CARRY_BIT = 15;
  localparam int SIZE_BIT = 14;
  localparam int DEST_BIT = 13;
  localparam int FADDR_HI = 12;
  localparam int DMODE_HI = 13;
  localparam int DMODE_LO = 11;
  localparam int DIDX_HI = 10;
  localparam int DIDX_LO = 7;
  localparam int SMODE_HI = 6;
  localparam int SMODE_LO = 4;
  localparam int SIDX_HI = 3;
  localparam int SIDX_LO = 0;
  // data widths
  localparam int BYTE_TOP = 7;
  localparam int WORD_TOP = 15;
  localparam logic [WIDX_W-1:0] WORKING_REG_ZERO = 4'h0;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [FADDR_W-1:0] FADDR_MAX = 13'h1FFF;

  // operation kinds
  typedef enum logic [1:0] {
    OP_ROTL_PLAIN,
    OP_ROTR_PLAIN,
    OP_ROTR_VIA_CARRY,
    OP_NONE
  } sbru_op_type;

  // write-back bundle produced per instruction
  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic byte_op;
    logic dest_is_file;
    logic [FADDR_W-1:0] file_addr;
    logic [WIDX_W-1:0] dst_idx;
    logic [MODE_W-1:0] dst_mode;
    logic [WIDX_W-1:0] src_idx;
    logic [MODE_W-1:0] src_mode;
    logic carry_we;
    logic carry;
    logic neg;
    logic zero;
  } sbru_res_type;
endpackage

// ==== dv/sbru_core_model.sv ====
// Purpose: far-side core model: working registers, data memory, carry flag
// Assumes: indirect modes read the register itself, no memory behind it
// Notes: writes the result back on the edge after o_done
`timescale 1ns/1ps
module sbru_core_model (
  input wire logic i_clk,
  input wire logic [sbru_pkg::INSTR_W-1:0] i_instr,
  input wire sbru_pkg::sbru_res_type i_res,
  input wire logic i_done,
  output logic [15:0] o_operand,
  output logic [15:0] o_dst_old,
  output logic o_carry
);
  logic [15:0] default_accum_reg [16];
  logic [15:0] fmem [8192];
  logic carry_r;
  // known contents from time zero
  initial begin
    foreach (default_accum_reg[i]) default_accum_reg[i] = 16'h0000;
    foreach (fmem[i]) fmem[i] = 16'h0000;
    carry_r = 1'b0;
  end
  // operand fetch and destination read
  assign o_operand = i_instr[18] ? fmem[i_instr[12:0]] : default_accum_reg[i_instr[3:0]];
  assign o_dst_old = i_instr[18] ? (i_instr[13] ? fmem[i_instr[12:0]] : default_accum_reg[0])
    : default_accum_reg[i_instr[10:7]];
  assign o_carry = carry_r;
  // result write-back and carry update
  always @(posedge i_clk) begin
    if (i_done) begin
      if (i_res.dest_is_file) fmem[i_res.file_addr] <= i_res.value;
      else default_accum_reg[i_res.dst_idx] <= i_res.value;
      if (i_res.carry_we) carry_r <= i_res.carry;
    end
  end
endmodule // sbru_core_model

// ==== dv/test_single_bit_rotate_unit.sv ====
// Purpose: table-driven bench for the rotate unit
// Assumes: fixed one-cycle answer, inputs driven at the falling edge
// Notes: flg holds carry write, carry, negative, zero
`timescale 1ns/1ps
module test_single_bit_rotate_unit;
  typedef struct packed {
    logic [23:0] instr;
    logic [15:0] src;
    logic [15:0] dst;
    logic cin;
    logic [15:0] val;
    logic [3:0] flg;
  } sbru_row_type;
  logic i_clk, i_rst, i_ce, i_valid, carry, o_done, o_illegal;
  logic [23:0] i_instr;
  logic [15:0] operand, dst_old;
  sbru_pkg::sbru_res_type o_res;
  int fail_count = 0;
  int check_count = 0;
  sbru_row_type rows [13] = '{
    '{24'hD60820, 16'h216E, 16'h5601, 1'b1, 16'h42DC, 4'h4},
    '{24'hD70820, 16'h216E, 16'h5601, 1'b1, 16'h10B7, 4'h4},
    '{24'hD78820, 16'h216E, 16'h5601, 1'b1, 16'h90B7, 4'hA},
    '{24'hD67233, 16'h5AE8, 16'h5AE8, 1'b0, 16'h5AD1, 4'h2},
    '{24'hD77233, 16'h5AE8, 16'h5AE8, 1'b0, 16'h5A74, 4'h0},
    '{24'hD77233, 16'h5A00, 16'h5A00, 1'b0, 16'h5A00, 4'h1},
    '{24'hD20180, 16'h9976, 16'h5879, 1'b1, 16'h58EC, 4'h6},
    '{24'hD24180, 16'h9976, 16'h5879, 1'b1, 16'h32ED, 4'h4},
    '{24'hD3C180, 16'h9976, 16'h5879, 1'b1, 16'h58BB, 4'hA},
    '{24'hD38C22, 16'hC041, 16'h094E, 1'b1, 16'hE020, 4'hE},
    '{24'hD61FFF, 16'h8000, 16'h0000, 1'b0, 16'h0001, 4'h0},
    '{24'hD34180, 16'h9976, 16'h5879, 1'b1, 16'h583B, 4'h4},
    '{24'hD7F233, 16'h5AE8, 16'h5AE8, 1'b1, 16'h5AF4, 4'hA}};
  sbru_rotate_unit sbru_rotate_unit_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_valid(i_valid), .i_instr(i_instr), .i_operand(operand), .i_dst_old(dst_old),
    .i_carry(carry), .o_res(o_res), .o_done(o_done), .o_illegal(o_illegal));
  sbru_core_model sbru_core_model_inst (.i_clk(i_clk), .i_instr(i_instr), .i_res(o_res),
    .i_done(o_done), .o_operand(operand), .o_dst_old(dst_old), .o_carry(carry));
  // value comparisons
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // flag comparisons
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({15'h0000, got}, {15'h0000, exp});
  endtask
  // preload the far side and present one instruction
  task automatic issue(input sbru_row_type r);
    if (r.instr[18]) begin
      sbru_core_model_inst.fmem[r.instr[12:0]] = r.src;
      if (!r.instr[13]) sbru_core_model_inst.default_accum_reg[0] = r.dst;
    end else begin
      sbru_core_model_inst.default_accum_reg[r.instr[3:0]] = r.src;
      sbru_core_model_inst.default_accum_reg[r.instr[10:7]] = r.dst;
    end
    sbru_core_model_inst.carry_r = r.cin;
    i_instr = r.instr;
    i_valid = 1'b1;
  endtask
  // compare the result fields against one row, dst_idx only when the file is not the destination
  task automatic check_row(input sbru_row_type r);
    logic wf;
    wf = !r.instr[18];
    cmp_bit(o_done, 1'b1);
    cmp_val(o_res.value, r.val);
    cmp_val({12'h000, o_res.carry_we, o_res.carry, o_res.neg, o_res.zero}, {12'h000, r.flg});
    cmp_bit(o_res.byte_op, (wf && !r.instr[16]) ? !r.instr[14] : r.instr[14]);
    cmp_bit(o_res.dest_is_file, r.instr[18] & r.instr[13]);
    if (wf || !r.instr[13]) cmp_val({12'h000, o_res.dst_idx}, {12'h000, wf ? r.instr[10:7] : 4'h0});
    cmp_val({3'h0, o_res.file_addr}, {3'h0, wf ? 13'h0000 : r.instr[12:0]});
    cmp_val({6'h00, o_res.dst_mode, o_res.src_mode, o_res.src_idx},
      wf ? {6'h00, r.instr[13:11], r.instr[6:4], r.instr[3:0]} : 16'h0000);
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_valid = 1'b0;
    i_instr = 24'hD60820;
    repeat (8) @(negedge i_clk);
    cmp_val(o_res.value, 16'h0000);
    cmp_bit(o_done, 1'b0);
    i_rst = 1'b0;
    foreach (rows[i]) begin
      issue(rows[i]);
      @(negedge i_clk);
      i_valid = 1'b0;
      check_row(rows[i]);
      @(negedge i_clk);
      cmp_bit(o_done, 1'b0);
    end
    // back to back, then a stalled enable
    issue(rows[0]);
    @(negedge i_clk);
    check_row(rows[0]);
    issue(rows[1]);
    @(negedge i_clk);
    check_row(rows[1]);
    i_ce = 1'b0;
    issue(rows[9]);
    @(negedge i_clk);
    cmp_val(o_res.value, rows[1].val);
    cmp_bit(o_done, 1'b1);
    i_ce = 1'b1;
    @(negedge i_clk);
    check_row(rows[9]);
    // left rotate through carry is refused
    i_instr = 24'hD68820;
    @(negedge i_clk);
    i_valid = 1'b0;
    cmp_bit(o_illegal, 1'b1);
    cmp_bit(o_done, 1'b0);
    cmp_val(o_res.value, rows[9].val);
    // reset in mid-run with a request pending
    issue(rows[2]);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    cmp_val(o_res.value, 16'h0000);
    cmp_bit(o_done, 1'b0);
    cmp_bit(o_illegal, 1'b0);
    i_rst = 1'b0;
    @(negedge i_clk);
    i_valid = 1'b0;
    check_row(rows[2]);
    conclude();
  end
endmodule // test_single_bit_rotate_unit
